// [tmr_defines.svh]
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_OFF_MODE 8'h00
`define TMR_OFF_CAPCTL 8'h04
`define TMR_OFF_OUTCTL 8'h08
`define TMR_OFF_CMP0 8'h0c
`define TMR_OFF_CMP1 8'h10
`define TMR_OFF_COUNT 8'h14
`define TMR_OFF_EDGE 8'h18
`define TMR_OFF_OSC 8'h1c
`define TMR_OFF_CLKSEL 8'h20

`define TMR_MODE_OVF_BIT 0
`define TMR_MODE_LSB 1
`define TMR_MODE_MSB 3
`define TMR_OC_PIN_EN_BIT 0
`define TMR_OC_INV0_BIT 1
`define TMR_OC_INV1_BIT 2
`define TMR_OC_INIT_BIT 3
`define TMR_OC_ONESHOT_BIT 4
`define TMR_OC_TRIG_BIT 6
`define TMR_EDGE_LSB 2
`define TMR_EDGE_MSB 3
`define TMR_OSC_SPEED_BIT 0
`define TMR_CLKSEL_LSB 0
`define TMR_CLKSEL_MSB 2

`define TMR_MODE_STOP 3'h0
`define TMR_MODE_CLR_EDGE 3'h2
`define TMR_MODE_CLR_MATCH 3'h3

`define TMR_EDGE_FALL 2'h0
`define TMR_EDGE_RISE 2'h1
`define TMR_EDGE_BOTH 2'h3

`define TMR_SRC_EXT_PIN 3'h4
`define TMR_SRC_WATCH 3'h5

`define TMR_RST_CMP 16'h0000
`define TMR_RST_BYTE 8'h00
`define TMR_COUNT_ALL 16'hffff

`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// [tmr_pkg.sv]
package tmr_pkg;

  typedef struct packed {
    logic pin_en;
    logic inv0;
    logic inv1;
    logic init_lvl;
    logic oneshot;
  } tmr_outctl_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2:0] mode;
    logic ovf;
    logic [7:0] capctl;
    tmr_outctl_t oc;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] count;
    logic busy;
    logic out_ff;
    logic pin_out;
    logic [1:0] edge_sel;
    logic speed;
    logic [2:0] clk_sel;
    logic [3:0] pre;
    logic trig_q;
    logic watch_q;
  } tmr_state_t;

endpackage

// [tmr_top.sv]
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module tmr_top
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TRIG_IN,
  input wire logic WATCH_IN,
  output logic PULSE_OUT
);

  // Address decode uses the low eight bits only
  if (ADDR_W < 8 || ADDR_W > 32) begin
    $error("ADDR_W must lie between 8 and 32");
  end

  tmr_state_t s_reg;
  tmr_state_t s_next;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    return w == `TMR_OFF_MODE || w == `TMR_OFF_CAPCTL ||
           w == `TMR_OFF_OUTCTL || w == `TMR_OFF_CMP0 ||
           w == `TMR_OFF_CMP1 || w == `TMR_OFF_COUNT ||
           w == `TMR_OFF_EDGE || w == `TMR_OFF_OSC ||
           w == `TMR_OFF_CLKSEL;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input tmr_state_t st);
    logic [31:0] r;
    r = 32'h0;
    case ({a[7:2], 2'h0})
      `TMR_OFF_MODE: begin
        r[`TMR_MODE_MSB:`TMR_MODE_LSB] = st.mode;
        r[`TMR_MODE_OVF_BIT] = st.ovf;
      end
      `TMR_OFF_CAPCTL: r[7:0] = st.capctl;
      `TMR_OFF_OUTCTL: begin
        r[`TMR_OC_PIN_EN_BIT] = st.oc.pin_en;
        r[`TMR_OC_INV0_BIT] = st.oc.inv0;
        r[`TMR_OC_INV1_BIT] = st.oc.inv1;
        r[`TMR_OC_INIT_BIT] = st.oc.init_lvl;
        r[`TMR_OC_ONESHOT_BIT] = st.oc.oneshot;
      end
      `TMR_OFF_CMP0: r[15:0] = st.cmp0;
      `TMR_OFF_CMP1: r[15:0] = st.cmp1;
      `TMR_OFF_COUNT: r[15:0] = st.count;
      `TMR_OFF_EDGE: r[`TMR_EDGE_MSB:`TMR_EDGE_LSB] = st.edge_sel;
      `TMR_OFF_OSC: r[`TMR_OSC_SPEED_BIT] = st.speed;
      `TMR_OFF_CLKSEL: r[`TMR_CLKSEL_MSB:`TMR_CLKSEL_LSB] = st.clk_sel;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // Prescaler tap for sel 0 to 3: divide by 2^(sel+1), halved when speed is set
  function automatic logic pre_tick(input logic [3:0] pre,
                                    input logic [2:0] sel,
                                    input logic speed);
    logic [3:0] mask;
    logic [2:0] sh;
    sh = sel + 3'(!speed);
    mask = 4'((5'h1 << sh) - 5'h1);
    return (pre & mask) == mask;
  endfunction

  logic running;
  logic trig_edge;
  logic watch_edge;
  logic tick;
  logic [15:0] cnt_inc;
  logic m0;
  logic m1;
  logic lo_hit;
  logic hi_hit;
  logic start;
  logic wr_go;
  logic [7:0] wa;
  logic [31:0] wv;
  logic [2:0] new_mode;

  always_comb begin
    s_next = s_reg;
    running = s_reg.mode != `TMR_MODE_STOP;
    start = 1'b0;
    lo_hit = 1'b0;
    hi_hit = 1'b0;
    new_mode = `TMR_MODE_STOP;
    wv = 32'h0;
    s_next.trig_q = TRIG_IN;
    s_next.watch_q = WATCH_IN;

    // Valid edge on the trigger pin, seen only while running
    case (s_reg.edge_sel)
      `TMR_EDGE_FALL: trig_edge = s_reg.trig_q & ~TRIG_IN;
      `TMR_EDGE_RISE: trig_edge = ~s_reg.trig_q & TRIG_IN;
      `TMR_EDGE_BOTH: trig_edge = s_reg.trig_q ^ TRIG_IN;
      default: trig_edge = 1'b0;
    endcase
    trig_edge = trig_edge & running;
    watch_edge = ~s_reg.watch_q & WATCH_IN;

    case (s_reg.clk_sel)
      `TMR_SRC_EXT_PIN: tick = trig_edge;
      `TMR_SRC_WATCH: tick = watch_edge;
      default: tick = pre_tick(s_reg.pre, s_reg.clk_sel, s_reg.speed);
    endcase
    tick = tick & running;
    s_next.pre = running ? s_reg.pre + 4'h1 : 4'h0;

    // Match fires on the tick that would bring the count to the compare
    cnt_inc = s_reg.count + 16'h1;
    m0 = tick && cnt_inc == s_reg.cmp0;
    m1 = tick && cnt_inc == s_reg.cmp1;
    if (tick) begin
      if (m0 && s_reg.mode == `TMR_MODE_CLR_MATCH) begin
        s_next.count = 16'h0;
      end else begin
        s_next.count = cnt_inc;
      end
    end

    if (s_reg.oc.oneshot) begin
      lo_hit = (s_reg.cmp1 < s_reg.cmp0) ? m1 : m0;
      hi_hit = (s_reg.cmp1 < s_reg.cmp0) ? m0 : m1;
      if (s_reg.busy && lo_hit) begin
        s_next.out_ff = ~s_reg.oc.init_lvl;
      end
      if (s_reg.busy && hi_hit) begin
        s_next.out_ff = s_reg.oc.init_lvl;
        s_next.busy = 1'b0;
      end
    end else begin
      s_next.out_ff = s_reg.out_ff ^ (m0 & s_reg.oc.inv0) ^
                      (m1 & s_reg.oc.inv1);
    end

    // Edge restart: ignored while a one-shot pulse is running
    if (s_reg.mode == `TMR_MODE_CLR_EDGE && trig_edge) begin
      if (!s_reg.oc.oneshot || !s_reg.busy) begin
        start = 1'b1;
      end
    end

    // AXI4-Lite write path: address and data taken in either order
    if (S_AXI_AWVALID && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.awaddr = 8'(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.wdata = S_AXI_WDATA;
      s_next.wstrb = S_AXI_WSTRB;
    end
    wr_go = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    wa = {s_reg.awaddr[7:2], 2'h0};
    if (wr_go) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = addr_known(wa) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      wv = merge(read_word(wa, s_reg), s_reg.wdata, s_reg.wstrb);
      case (wa)
        `TMR_OFF_MODE: begin
          new_mode = wv[`TMR_MODE_MSB:`TMR_MODE_LSB];
          s_next.mode = new_mode;
          if (!wv[`TMR_MODE_OVF_BIT]) begin
            s_next.ovf = 1'b0;
          end
          if (new_mode == `TMR_MODE_STOP) begin
            s_next.count = 16'h0;
            s_next.busy = 1'b0;
            s_next.pre = 4'h0;
          end else if (!running) begin
            s_next.count = 16'h0;
            s_next.pre = 4'h0;
          end
        end
        `TMR_OFF_CAPCTL: s_next.capctl = wv[7:0];
        `TMR_OFF_OUTCTL: begin
          s_next.oc.pin_en = wv[`TMR_OC_PIN_EN_BIT];
          s_next.oc.inv0 = wv[`TMR_OC_INV0_BIT];
          s_next.oc.inv1 = wv[`TMR_OC_INV1_BIT];
          s_next.oc.init_lvl = wv[`TMR_OC_INIT_BIT];
          s_next.oc.oneshot = wv[`TMR_OC_ONESHOT_BIT];
          s_next.out_ff = wv[`TMR_OC_INIT_BIT];
          if (wv[`TMR_OC_TRIG_BIT] && wv[`TMR_OC_ONESHOT_BIT] &&
              running) begin
            start = 1'b1;
          end
        end
        `TMR_OFF_CMP0: s_next.cmp0 = wv[15:0];
        `TMR_OFF_CMP1: s_next.cmp1 = wv[15:0];
        `TMR_OFF_EDGE: s_next.edge_sel = wv[`TMR_EDGE_MSB:`TMR_EDGE_LSB];
        `TMR_OFF_OSC: s_next.speed = wv[`TMR_OSC_SPEED_BIT];
        `TMR_OFF_CLKSEL: begin
          s_next.clk_sel = wv[`TMR_CLKSEL_MSB:`TMR_CLKSEL_LSB];
        end
        default: s_next.bresp = `TMR_RESP_SLVERR;
      endcase
    end else begin
      wv = 32'h0;
      new_mode = `TMR_MODE_STOP;
    end
    if (s_reg.bvalid && S_AXI_BREADY) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;

    // Clear and start; a one-shot start also restores the idle level and sets busy
    if (start) begin
      s_next.count = 16'h0;
      s_next.pre = 4'h0;
      if (s_next.oc.oneshot) begin
        s_next.busy = 1'b1;
        s_next.out_ff = s_next.oc.init_lvl;
      end
    end

    // Overflow sets after a register-write clear in the same cycle, but not in a cycle with a start
    if (tick && s_reg.count == `TMR_COUNT_ALL && !start) begin
      s_next.ovf = 1'b1;
    end

    // AXI4-Lite read path, one cycle to the answer
    if (S_AXI_ARVALID && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = read_word(8'(S_AXI_ARADDR), s_reg);
      s_next.rresp = addr_known(8'(S_AXI_ARADDR)) ? `TMR_RESP_OKAY :
                     `TMR_RESP_SLVERR;
    end else if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    s_next.pin_out = s_next.out_ff & s_next.oc.pin_en;
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.cmp0 <= `TMR_RST_CMP;
      s_reg.cmp1 <= `TMR_RST_CMP;
      s_reg.capctl <= `TMR_RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign S_AXI_AWREADY = s_reg.awready;
  assign S_AXI_WREADY = s_reg.wready;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_ARREADY = s_reg.arready;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign PULSE_OUT = s_reg.pin_out;

endmodule

// [tmr_top_asserts.sv]
`timescale 1ns/1ps
module tmr_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PULSE_OUT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_ar;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_aw;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  property p_rd_lat;
    s_ar |=> S_AXI_RVALID;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_aw_blk;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_aw_blk: assert property (p_aw_blk) else $error("write taken too early");
  property p_wr_lat;
    s_aw |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_trig_rd;
    s_ar ##0 S_AXI_ARADDR == 8'h08 |=> S_AXI_RDATA[6] == 1'b0;
  endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("strobe reads one");
  property p_unmap;
    s_ar ##0 S_AXI_ARADDR >= 8'h24 |=> S_AXI_RRESP == 2'h2 && !S_AXI_RDATA;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_rst;
    $rose(NRST) |-> !PULSE_OUT && S_AXI_AWREADY && !S_AXI_BVALID;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule

bind tmr_top tmr_chk #(.ADDR_W(ADDR_W)) tmr_chk_i (
  .REF_CLK(REF_CLK),
  .NRST(NRST),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY),
  .PULSE_OUT(PULSE_OUT)
);

// [tmr_pin_model.sv]
`timescale 1ns/1ps
module tmr_pin_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic wen,
  output logic trig,
  output logic watch
);
  initial begin
    trig = 1'b0;
    watch = 1'b0;
  end
  // Trigger pin holds its level unless a toggle is requested
  always @(posedge clk) begin
    if (fire) trig <= ~trig;
    if (wen) watch <= ~watch;
  end
endmodule

// [tmr_top_tb_top.sv]
`timescale 1ns/1ps
module tmr_top_tb_top;
  typedef struct {
    logic sp;
    logic [2:0] sel;
    logic [15:0] c;
    logic f;
    int h;
  } tmr_row_t;
  // Speed, clock source, compare zero, pin toggling, half period
  tmr_row_t sq[6] = '{
    '{1'b1, 3'h0, 16'h0002, 1'b0, 2},
    '{1'b1, 3'h0, 16'h0003, 1'b0, 3},
    '{1'b0, 3'h0, 16'h0003, 1'b0, 6},
    '{1'b1, 3'h1, 16'h0003, 1'b0, 6},
    '{1'b1, 3'h5, 16'h0003, 1'b0, 6},
    '{1'b1, 3'h4, 16'h0003, 1'b1, 6}
  };
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, fire = 1'b0;
  logic awr, wrdy, bv, arr, rv, trig, watch, pout;
  logic [1:0] br, rr, lb, r;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q, q2;
  int errors = 0, n_checks = 0, cyc = 0;

  always #5 clk = ~clk;

  tmr_top tmr_top_i (.REF_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .TRIG_IN(trig), .WATCH_IN(watch), .PULSE_OUT(pout));
  tmr_pin_model tmr_pin_model_i (.clk(clk), .fire(fire), .wen(1'b1),
    .trig(trig), .watch(watch));

  task end_of_test;
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    lb = br;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    d = rdat;
    r = rr;
  endtask

  task tg;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // Counts output cycles high in a window; optionally retriggers once
  task cnt(input int e, input logic rt);
    int n;
    logic f;
    n = 0;
    f = rt;
    repeat (40) begin
      @(posedge clk);
      if (pout === 1'b1) n++;
      fire <= f && pout;
      if (pout === 1'b1) f = 1'b0;
    end
    chk(n, e);
  endtask

  // Skips the first, possibly short, half period
  task hp(input int e);
    int n;
    logic p;
    n = 0;
    @(posedge clk);
    p = pout;
    while (pout === p) @(posedge clk);
    p = pout;
    while (pout === p) begin
      @(posedge clk);
      n++;
    end
    chk(n, e);
  endtask

  task ext(input logic [1:0] es, input int e1, e2, input logic rt);
    wr(8'h00, 32'h0);
    wr(8'h18, {28'h0, es, 2'h0});
    if (trig) tg;
    wr(8'h00, 32'h4);
    tg;
    cnt(e1, rt);
    tg;
    cnt(e2, rt);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h08, q);
    chk(q, 32'h0);
    wr(8'h24, 32'h1);
    chk({30'h0, lb}, 32'h2);
    rd(8'h24, q);
    chk({30'h0, r}, 32'h2);
    foreach (sq[i]) begin
      wr(8'h00, 32'h0);
      wr(8'h1c, {31'h0, sq[i].sp});
      wr(8'h20, {29'h0, sq[i].sel});
      wr(8'h0c, {16'h0, sq[i].c});
      wr(8'h08, 32'h3);
      wr(8'h00, 32'h6);
      fire <= sq[i].f;
      hp(sq[i].h);
      fire <= 1'b0;
    end
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h0c, 32'ha);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h51);
    cnt(8, 1'b0);
    rd(8'h08, q);
    chk(q, 32'h11);
    rd(8'h14, q);
    rd(8'h14, q2);
    chk(32'(q !== q2), 32'h1);
    wr(8'h00, 32'h0);
    rd(8'h14, q);
    chk(q, 32'h0);
    wr(8'h0c, 32'h2);
    wr(8'h10, 32'ha);
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h59);
    cnt(32, 1'b0);
    wr(8'h0c, 32'ha);
    wr(8'h10, 32'h2);
    wr(8'h08, 32'h11);
    ext(2'h1, 8, 0, 1'b0);
    ext(2'h0, 0, 8, 1'b0);
    ext(2'h3, 8, 8, 1'b1);
    end_of_test;
  end
endmodule
